/* rtl/csf_defs.svh */
// Addresses, field positions, limits and counts of the CAN status and event flag block.
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH
`define CSF_ADDR_W        8
`define CSF_ADDR_STATUS   8'h02
`define CSF_ADDR_EVENTS   8'h03
`define CSF_RSVD_ONES     3'h7
`define CSF_BIT_BUS_OFF   7
`define CSF_BIT_ERR_WARN  6
`define CSF_BIT_TX_ACT    5
`define CSF_BIT_RX_ACT    4
`define CSF_BIT_TX_DONE   3
`define CSF_BIT_TX_FREE   2
`define CSF_BIT_OVERRUN   1
`define CSF_BIT_RX_PEND   0
`define CSF_EV_WAKE       4
`define CSF_EV_OVERRUN    3
`define CSF_EV_ERROR      2
`define CSF_EV_TX         1
`define CSF_EV_RX         0
`define CSF_CNT_W         9
`define CSF_WARN_LIMIT    9'h060
`define CSF_TEC_MAX       9'h0FF
`define CSF_REC_PASSIVE   9'h07F
`define CSF_REC_REENTER   9'h077
`define CSF_STEP_SMALL    9'h001
`define CSF_STEP_LARGE    9'h008
`define CSF_BUS_FREE_NUM  8'h80
`define CSF_BUS_FREE_W    8
`endif

/* rtl/csf_pkg.sv */
// Types shared by the CAN status and event flag block and its neighbours.
package csf_pkg;
    // Levels and one-cycle events from the protocol engine.
    typedef struct packed {
        logic tx_active;
        logic rx_active;
        logic tx_success;
        logic tx_error;
        logic rx_error;
        logic rx_error_severe;
        logic rx_success;
        logic rx_no_room;
        logic rx_eof_valid;
        logic bus_free;
        logic quantum_tick;
    } csf_engine_t;
    // One-cycle commands decoded by the command register logic.
    typedef struct packed {
        logic tx_request;
        logic tx_abort;
        logic release_rx;
        logic clear_overrun;
        logic sleep_request;
    } csf_cmd_t;
    // Interrupt enables held by the control register logic.
    typedef struct packed {
        logic overrun;
        logic error;
        logic tx;
        logic rx;
    } csf_enable_t;
    // Bus presence state, one-hot.
    typedef enum logic [2:0] {
        CSF_BUS_ON  = 3'h1,
        CSF_BUS_OFF = 3'h2,
        CSF_RECOVER = 3'h4
    } csf_bus_state_t;
endpackage : csf_pkg

/* rtl/csf_status_flags.sv */
// Status register, event flag register and interrupt pin of the CAN controller.
//
// Function
// - Bus-off flag high off bus, low on.
// - Warning flag when any counter reaches 96.
// - Transmit-active flag follows frame sending.
// - Receive-active flag follows frame reception.
// - Both activity flags low means bus idle.
// - Done flag cleared on request, set on success.
// - Buffer-free flag low while frame waits/sends.
// - Transmit buffer writes dropped while buffer locked.
// - Overrun flag sticks until clear-overrun command.
// - Overrun reported only if frame valid late.
// - Pending flag cleared on release, reloaded next quantum.
// - Transmit counter over 255 forces bus-off, reset request.
// - After 128 bus-free events, recover and interrupt.
// - Error counters follow CAN 2.0B rules.
// - Pin low while flags set; read clears all.
// - Wake flag set on leaving sleep.
// - Overrun event flag on overrun rise, enabled.
// - Error event flag on warning/bus-off change.
// - Transmit event flag on buffer-free rise, enabled.
// - Receive event flag on pending-flag rise, enabled.
// - Writes to status register ignored.
// - Event register bits 7..5 read one.
// - Wake flag on refused sleep request.
`timescale 1ns/10ps
`include "csf_defs.svh"

module csf_status_flags
    import csf_pkg::*;
(
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Register port.
    input  wire logic [`CSF_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [7:0]                  reg_rdata,
    // Protocol engine, commands and control.
    input  wire csf_engine_t            engine,
    input  wire csf_cmd_t               cmd,
    input  wire csf_enable_t            irq_enable,
    input  wire logic                   reset_request,
    input  wire logic                   sleep_mode,
    input  wire logic                   rx_frames_waiting,
    // Transmit buffer write gate.
    input  wire logic                   txbuf_wr,
    output logic                        txbuf_wr_accept,
    // Outputs toward control logic.
    output logic                        set_reset_request,
    output logic                        bus_idle,
    // Open-drain interrupt pin, active low.
    input  wire logic                   irq_pin_in,
    output logic                        irq_out_n,
    output logic                        irq_oe
);

    // Status flags.
    logic                  bus_off_flag;
    logic                  error_warn_flag;
    logic                  transmit_active_flag;
    logic                  receive_active_flag;
    logic                  tx_done_flag;
    logic                  tx_buffer_free_flag;
    logic                  overrun_flag;
    logic                  rx_pending_flag;
    // Event flags, five live bits.
    logic [4:0]            event_flags_reg;
    logic [4:0]            next_event_flags;
    // Error counters and bus state.
    logic [`CSF_CNT_W-1:0] tx_err_count;
    logic [`CSF_CNT_W-1:0] rx_err_count;
    csf_bus_state_t        bus_state;
    logic [`CSF_BUS_FREE_W-1:0] bus_free_seen;
    // Edge history and helpers.
    logic                  prev_warn;
    logic                  prev_bus_off;
    logic                  prev_tx_free;
    logic                  prev_overrun;
    logic                  prev_rx_pending;
    logic                  prev_sleep;
    logic                  drop_armed;
    logic                  rx_holdoff;
    logic                  tx_pending;
    logic [2:0]            pin_sync;
    logic                  pin_low;
    logic                  events_read;
    logic                  enter_bus_off;
    logic                  leave_bus_off;
    logic [7:0]            status_byte;

    // Saturating add keeps the nine-bit counters from wrapping.
    function automatic logic [`CSF_CNT_W-1:0] sat_add(input logic [`CSF_CNT_W-1:0] a,
                                                      input logic [`CSF_CNT_W-1:0] b);
        logic [`CSF_CNT_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[`CSF_CNT_W] ? {`CSF_CNT_W{1'b1}} : s[`CSF_CNT_W-1:0];
    endfunction : sat_add

    // Decrement that stops at zero.
    function automatic logic [`CSF_CNT_W-1:0] dec_floor(input logic [`CSF_CNT_W-1:0] a);
        dec_floor = (a == '0) ? a : a - `CSF_STEP_SMALL;
    endfunction : dec_floor

    assign events_read   = reg_rd && (reg_addr == `CSF_ADDR_EVENTS);
    assign enter_bus_off = (bus_state == CSF_BUS_ON) && (tx_err_count > `CSF_TEC_MAX);
    assign leave_bus_off = (bus_state == CSF_RECOVER) && engine.bus_free
                           && (bus_free_seen == `CSF_BUS_FREE_NUM - 8'h01);

    // The interrupt pin is asynchronous to us; the last two stages must agree.
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_sync <= 3'h7;
            pin_low  <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[1:0], irq_pin_in};
            if (pin_sync[1] == pin_sync[2]) begin
                pin_low <= ~pin_sync[2];
            end
        end
    end

    // Bus presence: bus-off holds until reset request drops, then 128 bus-free events.
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_state     <= CSF_BUS_ON;
            bus_free_seen <= '0;
        end else begin
            case (bus_state)
                CSF_BUS_ON: begin
                    bus_free_seen <= '0;
                    if (enter_bus_off) begin
                        bus_state <= CSF_BUS_OFF;
                    end
                end
                CSF_BUS_OFF: begin
                    bus_free_seen <= '0;
                    if (!reset_request) begin
                        bus_state <= CSF_RECOVER;
                    end
                end
                CSF_RECOVER: begin
                    if (leave_bus_off) begin
                        bus_state <= CSF_BUS_ON;
                    end else if (engine.bus_free) begin
                        bus_free_seen <= bus_free_seen + 8'h01;
                    end
                end
                default: begin
                    bus_state     <= CSF_BUS_ON;
                    bus_free_seen <= '0;
                end
            endcase
        end
    end

    // Ask the control logic to raise reset request when going bus-off.
    always_ff @(posedge clk) begin
        if (rst) begin
            set_reset_request <= 1'b0;
        end else begin
            set_reset_request <= enter_bus_off;
        end
    end

    // Transmit error counter; frozen while off the bus, cleared on recovery.
    always_ff @(posedge clk) begin
        if (rst || leave_bus_off) begin
            tx_err_count <= '0;
        end else if (bus_state == CSF_BUS_ON) begin
            if (engine.tx_error) begin
                tx_err_count <= sat_add(tx_err_count, `CSF_STEP_LARGE);
            end else if (engine.tx_success) begin
                tx_err_count <= dec_floor(tx_err_count);
            end
        end
    end

    // Receive error counter; a success above passive level drops back to 119.
    always_ff @(posedge clk) begin
        if (rst || leave_bus_off) begin
            rx_err_count <= '0;
        end else if (bus_state == CSF_BUS_ON) begin
            if (engine.rx_error_severe) begin
                rx_err_count <= sat_add(rx_err_count, `CSF_STEP_LARGE);
            end else if (engine.rx_error) begin
                rx_err_count <= sat_add(rx_err_count, `CSF_STEP_SMALL);
            end else if (engine.rx_success) begin
                if (rx_err_count > `CSF_REC_PASSIVE) begin
                    rx_err_count <= `CSF_REC_REENTER;
                end else begin
                    rx_err_count <= dec_floor(rx_err_count);
                end
            end
        end
    end

    // Bus and error status flags follow the bus state and counters.
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_off_flag    <= 1'b0;
            error_warn_flag <= 1'b0;
        end else begin
            bus_off_flag    <= (bus_state != CSF_BUS_ON) || enter_bus_off;
            if (leave_bus_off) begin
                error_warn_flag <= 1'b0;
            end else begin
                error_warn_flag <= (tx_err_count >= `CSF_WARN_LIMIT)
                                   || (rx_err_count >= `CSF_WARN_LIMIT);
            end
        end
    end

    // Activity flags mirror the engine; both low reports an idle bus.
    always_ff @(posedge clk) begin
        if (rst) begin
            transmit_active_flag <= 1'b0;
            receive_active_flag  <= 1'b0;
            bus_idle             <= 1'b1;
        end else begin
            transmit_active_flag <= engine.tx_active;
            receive_active_flag  <= engine.rx_active;
            bus_idle             <= !engine.tx_active && !engine.rx_active;
        end
    end

    // Transmit request bookkeeping; an abort only cancels a frame not yet on the bus.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_pending   <= 1'b0;
            tx_done_flag <= 1'b1;
        end else begin
            if (engine.tx_success) begin
                tx_done_flag <= 1'b1;
            end else if (cmd.tx_request) begin
                tx_done_flag <= 1'b0;
            end
            if (cmd.tx_request) begin
                tx_pending <= 1'b1;
            end else if (engine.tx_success || (cmd.tx_abort && !engine.tx_active)) begin
                tx_pending <= 1'b0;
            end
        end
    end

    // Buffer-free flag is registered so writes in its low phase are dropped quietly.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_buffer_free_flag <= 1'b1;
            txbuf_wr_accept     <= 1'b0;
        end else begin
            tx_buffer_free_flag <= !tx_pending && !cmd.tx_request;
            txbuf_wr_accept     <= txbuf_wr && tx_buffer_free_flag;
        end
    end

    // Overrun: a dropped frame counts only if it stays valid to the next-to-last EOF bit.
    always_ff @(posedge clk) begin
        if (rst) begin
            drop_armed   <= 1'b0;
            overrun_flag <= 1'b0;
        end else begin
            if (engine.rx_no_room) begin
                drop_armed <= 1'b1;
            end else if (engine.rx_error || engine.rx_eof_valid) begin
                drop_armed <= 1'b0;
            end
            if (drop_armed && engine.rx_eof_valid && !engine.rx_error) begin
                overrun_flag <= 1'b1;
            end else if (cmd.clear_overrun) begin
                overrun_flag <= 1'b0;
            end
        end
    end

    // A release hides the next frame until the following quantum tick.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_holdoff      <= 1'b0;
            rx_pending_flag <= 1'b0;
        end else begin
            if (cmd.release_rx) begin
                rx_holdoff <= 1'b1;
            end else if (engine.quantum_tick) begin
                rx_holdoff <= 1'b0;
            end
            if (cmd.release_rx) begin
                rx_pending_flag <= 1'b0;
            end else if (!rx_holdoff || engine.quantum_tick) begin
                rx_pending_flag <= rx_frames_waiting;
            end
        end
    end

    // Previous values feed the edge-sensitive event sources.
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_warn       <= 1'b0;
            prev_bus_off    <= 1'b0;
            prev_tx_free    <= 1'b1;
            prev_overrun    <= 1'b0;
            prev_rx_pending <= 1'b0;
            prev_sleep      <= 1'b0;
        end else begin
            prev_warn       <= error_warn_flag;
            prev_bus_off    <= bus_off_flag;
            prev_tx_free    <= tx_buffer_free_flag;
            prev_overrun    <= overrun_flag;
            prev_rx_pending <= rx_pending_flag;
            prev_sleep      <= sleep_mode;
        end
    end

    // Event sources are ORed in after the read clear, so an event in the read cycle survives.
    always_comb begin
        next_event_flags = events_read ? 5'h00 : event_flags_reg;
        if ((prev_sleep && !sleep_mode)
            || (cmd.sleep_request && (engine.tx_active || engine.rx_active
                                      || (event_flags_reg != 5'h00) || pin_low))) begin
            next_event_flags[`CSF_EV_WAKE] = 1'b1;
        end
        if (irq_enable.overrun && overrun_flag && !prev_overrun) begin
            next_event_flags[`CSF_EV_OVERRUN] = 1'b1;
        end
        if (irq_enable.error && ((error_warn_flag != prev_warn) || (bus_off_flag != prev_bus_off))) begin
            next_event_flags[`CSF_EV_ERROR] = 1'b1;
        end
        if (irq_enable.tx && tx_buffer_free_flag && !prev_tx_free) begin
            next_event_flags[`CSF_EV_TX] = 1'b1;
        end
        if (irq_enable.rx && rx_pending_flag && !prev_rx_pending) begin
            next_event_flags[`CSF_EV_RX] = 1'b1;
        end
    end

    // Event register and the open-drain pin that it pulls low.
    always_ff @(posedge clk) begin
        if (rst) begin
            event_flags_reg <= 5'h00;
            irq_oe          <= 1'b0;
            irq_out_n       <= 1'b0;
        end else begin
            event_flags_reg <= next_event_flags;
            irq_oe          <= (next_event_flags != 5'h00);
            irq_out_n       <= 1'b0;
        end
    end

    // Status byte, assembled from the flags only; writes never reach it.
    always_comb begin
        status_byte                     = 8'h00;
        status_byte[`CSF_BIT_BUS_OFF]   = bus_off_flag;
        status_byte[`CSF_BIT_ERR_WARN]  = error_warn_flag;
        status_byte[`CSF_BIT_TX_ACT]    = transmit_active_flag;
        status_byte[`CSF_BIT_RX_ACT]    = receive_active_flag;
        status_byte[`CSF_BIT_TX_DONE]   = tx_done_flag;
        status_byte[`CSF_BIT_TX_FREE]   = tx_buffer_free_flag;
        status_byte[`CSF_BIT_OVERRUN]   = overrun_flag;
        status_byte[`CSF_BIT_RX_PEND]   = rx_pending_flag;
    end

    // Read data stands one cycle after the strobe; unmapped and idle cycles give zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reg_addr == `CSF_ADDR_STATUS) begin
            reg_rdata <= status_byte;
        end else if (events_read) begin
            reg_rdata <= {`CSF_RSVD_ONES, event_flags_reg};
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : csf_status_flags

/* dv/csf_status_flags_properties.sv */
// Port-level checks of the CAN status and event flag block.
`timescale 1ns/10ps
`include "csf_defs.svh"

module csf_flags_checker
    import csf_pkg::*;
(
    // Clock and reset.
    input wire logic                   clk,
    input wire logic                   rst,
    // Register port.
    input wire logic [`CSF_ADDR_W-1:0] reg_addr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    // Engine and commands.
    input wire csf_engine_t            engine,
    input wire csf_cmd_t               cmd,
    input wire logic                   sleep_mode,
    // Outputs under watch.
    input wire logic                   txbuf_wr,
    input wire logic                   txbuf_wr_accept,
    input wire logic                   set_reset_request,
    input wire logic                   bus_idle,
    input wire logic                   irq_out_n,
    input wire logic                   irq_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Remembers an event register read, the only thing allowed to drop the pin.
    logic ev_rd;
    always_ff @(posedge clk) begin
        ev_rd <= !rst && reg_rd && reg_addr == 8'h03;
    end

    read_quiet_a: assert property (!(reg_rd && (reg_addr == 8'h02 || reg_addr == 8'h03)) |=> reg_rdata == 8'h00)
        else $error("read data without a mapped read");
    event_rsvd_a: assert property (reg_rd && reg_addr == 8'h03 |=> reg_rdata[7:5] == 3'h7)
        else $error("reserved event bits not one");
    irq_release_a: assert property ($fell(irq_oe) |-> ev_rd)
        else $error("interrupt released without event read");
    irq_drive_a: assert property (irq_oe |-> irq_out_n == 1'b0)
        else $error("interrupt pin driven high");
    accept_cause_a: assert property (txbuf_wr_accept |-> $past(txbuf_wr))
        else $error("buffer accept without a write");
    tx_lock_a: assert property (cmd.tx_request && !cmd.tx_abort && !engine.tx_success ##2 txbuf_wr |=> !txbuf_wr_accept)
        else $error("buffer write accepted while locked");
    idle_view_a: assert property (1'b1 |=> bus_idle == !($past(engine.tx_active) || $past(engine.rx_active)))
        else $error("bus idle wrong");
    busoff_pulse_a: assert property (set_reset_request |=> !set_reset_request)
        else $error("reset request pulse too long");
    busoff_cause_a: assert property (set_reset_request |-> $past(engine.tx_error) || $past(engine.tx_error, 2))
        else $error("bus-off without transmit error");
    wake_event_a: assert property ($fell(sleep_mode) |-> ##[1:3] irq_oe)
        else $error("no wake interrupt");
endmodule : csf_flags_checker

bind csf_status_flags csf_flags_checker u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .engine(engine), .cmd(cmd), .sleep_mode(sleep_mode), .txbuf_wr(txbuf_wr),
    .txbuf_wr_accept(txbuf_wr_accept), .set_reset_request(set_reset_request), .bus_idle(bus_idle),
    .irq_out_n(irq_out_n), .irq_oe(irq_oe));

/* dv/csf_host_model.sv */
// Host model: register port master and the pulled-up interrupt wire.
`timescale 1ns/10ps

module csf_host_model (
    // Clock.
    input  wire logic       clk,
    // Register port master.
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    // Interrupt wire.
    input  wire logic       irq_out_n,
    input  wire logic       irq_oe,
    output logic            irq_wire
);
    // The wire has a pull-up, so it floats high once the device lets go.
    assign irq_wire = irq_oe ? irq_out_n : 1'b1;

    // Idle bus at time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One-cycle write; data is scrambled afterwards so stale values never look valid.
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr

    // One-cycle read; data stands the cycle after the strobe and is taken at the edge that ends it.
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
endmodule : csf_host_model

/* dv/tb_top.sv */
// Self-checking bench of the CAN status and event flag block.
`timescale 1ns/10ps

module tb_top;
    import csf_pkg::*;
    localparam logic [10:0] E_OK = 11'h100, E_TERR = 11'h080, E_RERR = 11'h040;
    localparam logic [10:0] E_ROOM = 11'h008, E_EOF = 11'h004, E_BF = 11'h002, E_QT = 11'h001;
    localparam logic [4:0]  C_TR = 5'h10, C_REL = 5'h04, C_CLR = 5'h02, C_SLP = 5'h01;
    logic        clk = 1'b0;
    logic        rst, reg_wr, reg_rd, reset_request, sleep_mode, rx_frames_waiting;
    logic        txbuf_wr, txbuf_wr_accept, set_reset_request, bus_idle, irq_wire, irq_out_n, irq_oe;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    csf_engine_t engine;
    csf_cmd_t    cmd;
    csf_enable_t irq_enable;
    int          errors, n_compared, cyc, n_srr;

    csf_status_flags dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .engine(engine), .cmd(cmd), .irq_enable(irq_enable),
        .reset_request(reset_request), .sleep_mode(sleep_mode), .rx_frames_waiting(rx_frames_waiting),
        .txbuf_wr(txbuf_wr), .txbuf_wr_accept(txbuf_wr_accept), .set_reset_request(set_reset_request),
        .bus_idle(bus_idle), .irq_pin_in(irq_wire), .irq_out_n(irq_out_n), .irq_oe(irq_oe));
    csf_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out_n(irq_out_n), .irq_oe(irq_oe), .irq_wire(irq_wire));

    // Clock, bus-off pulse count and hang guard.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (set_reset_request === 1'b1) n_srr++;
        cyc++;
        if (cyc == 5000) begin
            errors++;
            results();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task results();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // One-cycle engine pulse, then one quiet cycle.
    task pe(input logic [10:0] p);
        @(posedge clk);
        engine <= engine | p;
        @(posedge clk);
        engine <= engine & ~p;
    endtask : pe

    task pc(input logic [4:0] p);
        @(posedge clk);
        cmd <= p;
        @(posedge clk);
        cmd <= 5'h00;
    endtask : pc

    task rs(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask : rs

    // Host write into the transmit buffer and its acceptance.
    task tw(input logic exp);
        @(posedge clk);
        txbuf_wr <= 1'b1;
        @(posedge clk);
        txbuf_wr <= 1'b0;
        @(posedge clk);
        chk({7'h00, txbuf_wr_accept}, {7'h00, exp});
    endtask : tw

    // Main sequence; flags settle within two cycles of their cause.
    initial begin
        rst = 1'b1;
        engine = '0;
        cmd = '0;
        irq_enable = '0;
        {reset_request, sleep_mode, rx_frames_waiting, txbuf_wr} = 4'h0;
        tick(16);
        rst <= 1'b0;
        rs(8'h02, 8'h0C);
        rs(8'h03, 8'hE0);
        host.wr(8'h02, 8'hFF);
        rs(8'h02, 8'h0C);
        rs(8'h07, 8'h00);
        tw(1'b1);
        pc(C_TR);
        tw(1'b0);
        rs(8'h02, 8'h00);
        engine.tx_active <= 1'b1;
        tick(2);
        chk({7'h00, bus_idle}, 8'h00);
        rs(8'h02, 8'h20);
        engine <= 11'h200;
        rs(8'h02, 8'h10);
        engine <= '0;
        pe(E_OK);
        tick(1);
        chk({7'h00, bus_idle}, 8'h01);
        rs(8'h02, 8'h0C);
        rs(8'h03, 8'hE0);
        irq_enable <= 4'hF;
        pc(C_TR);
        pe(E_OK);
        tick(3);
        chk({7'h00, irq_wire}, 8'h00);
        rs(8'h03, 8'hE2);
        chk({7'h00, irq_wire}, 8'h01);
        rs(8'h03, 8'hE0);
        rx_frames_waiting <= 1'b1;
        tick(2);
        rs(8'h02, 8'h0D);
        rs(8'h03, 8'hE1);
        pc(C_REL);
        rs(8'h02, 8'h0C);
        pe(E_QT);
        tick(1);
        rs(8'h02, 8'h0D);
        rs(8'h03, 8'hE1);
        rx_frames_waiting <= 1'b0;
        pc(C_REL);
        pe(E_QT);
        pe(E_ROOM);
        pe(E_EOF);
        tick(1);
        rs(8'h02, 8'h0E);
        rs(8'h03, 8'hE8);
        pc(C_CLR);
        rs(8'h02, 8'h0C);
        pe(E_ROOM);
        pe(E_RERR);
        pe(E_EOF);
        rs(8'h02, 8'h0C);
        repeat (11) pe(E_TERR);
        rs(8'h02, 8'h0C);
        pe(E_TERR);
        tick(1);
        rs(8'h02, 8'h4C);
        rs(8'h03, 8'hE4);
        repeat (20) pe(E_TERR);
        tick(1);
        reset_request <= 1'b1;
        rs(8'h02, 8'hCC);
        chk(n_srr[7:0], 8'h01);
        rs(8'h03, 8'hE4);
        repeat (4) pe(E_BF);
        reset_request <= 1'b0;
        repeat (127) pe(E_BF);
        rs(8'h02, 8'hCC);
        pe(E_BF);
        tick(1);
        rs(8'h02, 8'h0C);
        rs(8'h03, 8'hE4);
        repeat (11) pe(E_TERR);
        rs(8'h02, 8'h0C);
        sleep_mode <= 1'b1;
        tick(2);
        sleep_mode <= 1'b0;
        tick(2);
        rs(8'h03, 8'hF0);
        engine.tx_active <= 1'b1;
        pc(C_SLP);
        tick(2);
        rs(8'h03, 8'hF0);
        engine.tx_active <= 1'b0;
        tick(2);
        results();
    end
endmodule : tb_top
